// ### rtl/dual_pin_port.sv
// two pin ports with control registers on an axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
//
// Contract
// - drive pin with output value when enabled
// - bit 4 enables driver, else high impedance
// - level mode clocks pin into capture bit
// - edge mode sets capture bit, sticky
// - writing clear one zeroes capture bit
// - level mode bit 1 inverts sample
// - edge mode bit 1 picks falling edge
// - bit 0 selects edge or level mode
// - pin qualified after four stable periods
// - clear held suspends level tracking
// - clear held suspends edge detection
// - second port identical at index 41h
module dual_pin_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [pin_port_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [pin_port_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port pins, split into input, output and enable
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // write channels and answer
    logic aw_held;
    logic [pin_port_pkg::addr_width-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    // read answer
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    // control registers
    pin_port_pkg::port_cfg_t cfg1;
    pin_port_pkg::port_cfg_t cfg2;
    // interrupt
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    // registered pin drivers
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } top_state_t;

  // register selected by a bus address
  typedef enum logic [2:0] {
    sel_none,
    sel_port_one,
    sel_port_two,
    sel_status,
    sel_mask
  } reg_sel_t;

  top_state_t s_q;
  top_state_t s_d;
  logic [1:0] level;
  logic [1:0] capture;
  logic [1:0] edge_seen;
  logic do_write;
  logic do_read;
  logic [pin_port_pkg::addr_width-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] ctrl_image(input pin_port_pkg::port_cfg_t c,
                                              input logic cap);
    logic [15:0] v;
    v = pin_port_pkg::ctrl_reset;
    v[pin_port_pkg::output_value_bit] = c.output_value;
    v[pin_port_pkg::drive_enable_bit] = c.drive_enable;
    v[pin_port_pkg::capture_bit_pos] = cap;
    v[pin_port_pkg::capture_clear_bit] = c.capture_clear;
    v[pin_port_pkg::invert_or_falling_bit] = c.invert_or_falling;
    v[pin_port_pkg::edge_mode_bit] = c.edge_mode;
    return v; // upper bits stay zero
  endfunction

  function automatic pin_port_pkg::port_cfg_t ctrl_write(
      input pin_port_pkg::port_cfg_t c, input logic [31:0] d, input logic [3:0] be);
    pin_port_pkg::port_cfg_t n;
    n = c;
    // only the low byte holds writable fields; bits 15..6 are dropped
    if (be[0]) begin
      n.output_value = d[pin_port_pkg::output_value_bit];
      n.drive_enable = d[pin_port_pkg::drive_enable_bit];
      n.capture_clear = d[pin_port_pkg::capture_clear_bit];
      n.invert_or_falling = d[pin_port_pkg::invert_or_falling_bit];
      n.edge_mode = d[pin_port_pkg::edge_mode_bit];
    end
    return n;
  endfunction

  // one place turns a byte address into a register select
  function automatic reg_sel_t decode_addr(input logic [pin_port_pkg::addr_width-1:0] a);
    reg_sel_t s;
    case (a)
      pin_port_pkg::port_one_ctrl_addr: begin
        s = sel_port_one;
      end
      pin_port_pkg::port_two_ctrl_addr: begin
        s = sel_port_two;
      end
      pin_port_pkg::irq_status_addr: begin
        s = sel_status;
      end
      pin_port_pkg::irq_mask_addr: begin
        s = sel_mask;
      end
      default: begin
        s = sel_none;
      end
    endcase
    return s;
  endfunction

  function automatic logic addr_mapped(input logic [pin_port_pkg::addr_width-1:0] a);
    return decode_addr(a) != sel_none;
  endfunction

  function automatic logic [1:0] bus_resp(input logic [pin_port_pkg::addr_width-1:0] a);
    return addr_mapped(a) ? pin_port_pkg::resp_okay : pin_port_pkg::resp_slverr;
  endfunction

  // a read clears the status, but an event in that same cycle wins
  function automatic logic [1:0] status_next(input logic [1:0] status,
                                             input logic clear,
                                             input logic [1:0] events);
    logic [1:0] n;
    n = clear ? 2'b00 : status;
    return n | events;
  endfunction

  // read image of one register; unmapped words read as zero
  function automatic logic [31:0] read_word(input reg_sel_t sel,
                                            input pin_port_pkg::port_cfg_t c1,
                                            input pin_port_pkg::port_cfg_t c2,
                                            input logic [1:0] cap,
                                            input logic [1:0] status,
                                            input logic [1:0] mask);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (sel)
      sel_port_one: begin
        w[15:0] = ctrl_image(c1, cap[0]);
      end
      sel_port_two: begin
        w[15:0] = ctrl_image(c2, cap[1]);
      end
      sel_status: begin
        w[1:0] = status;
      end
      sel_mask: begin
        w[1:0] = mask;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // per-port input path, one instance pair per port
  // ----------------------------------------------------------------
  pin_input_filter u_filt1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in[0]),
    .level_out(level[0])
  );

  pin_input_filter u_filt2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(pin_in[1]),
    .level_out(level[1])
  );

  pin_capture_unit u_cap1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(s_q.cfg1),
    .level_in(level[0]),
    .capture(capture[0]),
    .edge_seen(edge_seen[0])
  );

  // second port: same logic, own register and pin
  pin_capture_unit u_cap2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(s_q.cfg2),
    .level_in(level[1]),
    .capture(capture[1]),
    .edge_seen(edge_seen[1])
  );

  // ----------------------------------------------------------------
  // bus slave: channel readiness
  // ----------------------------------------------------------------
  // a held channel or a pending answer stalls only that side; reads and
  // writes run independently, one of each at a time
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;

  always_comb begin
    s_d = s_q;

    // ----------------------------------------------------------------
    // write address and data, taken in either order
    // ----------------------------------------------------------------
    wr_addr = s_q.aw_held ? s_q.aw_addr : s_axi_awaddr;
    wr_data = s_q.w_held ? s_q.w_data : s_axi_wdata;
    wr_strb = s_q.w_held ? s_q.w_strb : s_axi_wstrb;
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    // the write lands in the cycle that completes the pair
    do_write = s_d.aw_held && s_d.w_held && !s_q.bvalid;
    do_read = s_axi_arvalid && s_axi_arready;

    // ----------------------------------------------------------------
    // interrupt status: edge captures are sticky events
    // ----------------------------------------------------------------
    s_d.irq_status = status_next(s_q.irq_status,
                                 do_read && (decode_addr(s_axi_araddr) == sel_status),
                                 edge_seen);

    // ----------------------------------------------------------------
    // write commit and response
    // ----------------------------------------------------------------
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = bus_resp(wr_addr);
      case (decode_addr(wr_addr))
        sel_port_one: begin
          s_d.cfg1 = ctrl_write(s_q.cfg1, wr_data, wr_strb);
        end
        sel_port_two: begin
          s_d.cfg2 = ctrl_write(s_q.cfg2, wr_data, wr_strb);
        end
        sel_mask: begin
          if (wr_strb[0]) begin
            s_d.irq_mask = wr_data[1:0];
          end
        end
        default: begin
          // status is read-only and unmapped words are dropped
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // read response
    // ----------------------------------------------------------------
    if (do_read) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = bus_resp(s_axi_araddr);
      s_d.rdata = read_word(decode_addr(s_axi_araddr), s_q.cfg1, s_q.cfg2, capture,
                            s_q.irq_status, s_q.irq_mask);
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // taken from the next control fields so a write reaches the pin
    // at the same edge that raises the bus answer
    s_d.pin_out[0] = s_d.cfg1.output_value;
    s_d.pin_oe[0] = s_d.cfg1.drive_enable;
    s_d.pin_out[1] = s_d.cfg2.output_value;
    s_d.pin_oe[1] = s_d.cfg2.drive_enable;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;
  assign pin_out = s_q.pin_out;
  assign pin_oe = s_q.pin_oe;
  assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule

// ### rtl/pin_port_pkg.sv
// shared constants and carrier types for the dual pin port block
package pin_port_pkg;

  // ----------------------------------------------------------------
  // register map (printed offsets 40h/41h are indices, byte addr = 4x)
  // ----------------------------------------------------------------
  localparam logic [7:0] port_one_ctrl_index = 8'h40;
  localparam logic [7:0] port_two_ctrl_index = 8'h41;
  localparam logic [9:0] port_one_ctrl_addr = 10'h100;
  localparam logic [9:0] port_two_ctrl_addr = 10'h104;
  localparam logic [9:0] irq_status_addr = 10'h010;
  localparam logic [9:0] irq_mask_addr = 10'h014;
  localparam int addr_width = 10;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int ctrl_width = 16;
  localparam int output_value_bit = 5;
  localparam int drive_enable_bit = 4;
  localparam int capture_bit_pos = 3;
  localparam int capture_clear_bit = 2;
  localparam int invert_or_falling_bit = 1;
  localparam int edge_mode_bit = 0;
  localparam logic [15:0] ctrl_write_mask = 16'h0037;
  localparam logic [15:0] ctrl_reset = 16'h0000;

  // ----------------------------------------------------------------
  // timing: qualify over four oscillator periods
  // ----------------------------------------------------------------
  localparam int stable_periods = 4;
  localparam int clock_period_ns = 40;
  localparam int stable_cycles = stable_periods;
  localparam int stable_cnt_width = 3;

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic output_value;
    logic drive_enable;
    logic capture_clear;
    logic invert_or_falling;
    logic edge_mode;
  } port_cfg_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic stable;
    logic cand;
  } filt_state_t;

  typedef struct packed {
    logic capture;
    logic prev_level;
    logic primed;
  } cap_state_t;

endpackage

// ### rtl/pin_input_filter.sv
// input qualifier: passes a pin level only after it holds four cycles
`timescale 1ns/1ps
module pin_input_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pin sample and qualified level
  input wire logic pin_in,
  output logic level_out
);

  pin_port_pkg::filt_state_t s_q;
  pin_port_pkg::filt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (pin_in != s_q.cand) begin
      s_d.cand = pin_in;
      s_d.cnt = 3'd1;
    end else if (s_q.cnt < 3'(pin_port_pkg::stable_cycles)) begin
      s_d.cnt = s_q.cnt + 3'd1;
    end
    // accept the new level once it has held the full window
    if (s_d.cnt == 3'(pin_port_pkg::stable_cycles)) begin
      s_d.stable = s_d.cand;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.stable;

endmodule

// ### rtl/pin_capture_unit.sv
// capture logic for one port: level tracking or sticky edge latch
`timescale 1ns/1ps
module pin_capture_unit (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration and qualified pin level
  input pin_port_pkg::port_cfg_t cfg,
  input wire logic level_in,
  // capture result
  output logic capture,
  output logic edge_seen
);

  pin_port_pkg::cap_state_t s_q;
  pin_port_pkg::cap_state_t s_d;
  logic edge_hit;

  always_comb begin
    s_d = s_q;
    s_d.prev_level = level_in;
    s_d.primed = 1'b1;
    // falling when the select bit is 1, rising when 0
    if (cfg.invert_or_falling) begin
      edge_hit = s_q.primed && s_q.prev_level && !level_in;
    end else begin
      edge_hit = s_q.primed && !s_q.prev_level && level_in;
    end
    if (cfg.capture_clear) begin
      // clear forces zero and holds tracking and detection off
      s_d.capture = 1'b0;
      edge_hit = 1'b0;
    end else if (cfg.edge_mode) begin
      // edge mode: sticky one until cleared
      if (edge_hit) begin
        s_d.capture = 1'b1;
      end
    end else begin
      // level mode: track the pin, optionally inverted
      s_d.capture = level_in ^ cfg.invert_or_falling;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign capture = s_q.capture;
  assign edge_seen = edge_hit && cfg.edge_mode;

endmodule

// ### verif/pin_drivers.sv
// outside world wired to the two port pins
`timescale 1ns/1ps
module pin_drivers (
  // port side
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  // outside source, always driving
  input wire logic [1:0] ext_level,
  output logic [1:0] pin_level
);
  // a driven pin shows the port value, a released one the outside source
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ### verif/dual_pin_port_checker.sv
// bus and pin assertions for the dual pin port
`timescale 1ns/1ps
module dual_pin_port_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [pin_port_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and interrupt
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  input wire logic irq
);
  logic go;
  logic p1;
  logic p2;
  logic no_hs;
  assign go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign p1 = go && s_axi_wstrb[0] && s_axi_awaddr == pin_port_pkg::port_one_ctrl_addr;
  assign p2 = go && s_axi_wstrb[0] && s_axi_awaddr == pin_port_pkg::port_two_ctrl_addr;
  // a write completes only in a cycle that takes address or data
  assign no_hs = !(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_B_ANSWER: assert property (go |=> s_axi_bvalid) else $error("write unanswered");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read unanswered");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_HIGH_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == '0)
    else $error("unused bits not zero");
  AST_P1_VALUE: assert property (p1 |=> pin_out[0] == $past(s_axi_wdata[5]))
    else $error("port one value");
  AST_P1_ENABLE: assert property (p1 |=> pin_oe[0] == $past(s_axi_wdata[4]))
    else $error("port one enable");
  AST_P2_PINS: assert property (p2 |=> {pin_out[1], pin_oe[1]} == $past(s_axi_wdata[5:4]))
    else $error("port two pins");
  AST_PINS_HOLD: assert property (no_hs |=> $stable(pin_oe) && $stable(pin_out))
    else $error("pins moved without write");
  cover property (irq);
  cover property (p2);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind dual_pin_port dual_pin_port_checker chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));

// ### verif/tb_dual_pin_port.sv
// self-checking bench for the dual pin port
`timescale 1ns/1ps
module tb_dual_pin_port;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, pin_in, pin_out, pin_oe, ext;
  int n_mismatch, compares;
  localparam logic [9:0] a1 = pin_port_pkg::port_one_ctrl_addr;
  localparam logic [9:0] a2 = pin_port_pkg::port_two_ctrl_addr;
  localparam logic [9:0] ast = pin_port_pkg::irq_status_addr;
  dual_pin_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  pin_drivers far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pin_in));
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // handshakes are judged at the falling edge, where every signal has settled
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input bit slow = 0);
    int n;
    logic ha, hw, hb;
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wvalid <= 1;
    bready <= !slow;
    n = 0;
    hb = 0;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      rs = bresp;
      n++;
      if (n > 40) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge aclk);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
      if (hb) bready <= 0;
      else if (n == 3) bready <= 1;
    end
    // let an edge pass so a following call never re-drives bready in this step
    @(posedge aclk);
  endtask
  task automatic rd_reg(input logic [9:0] a, input bit slow = 0);
    int n;
    logic ha, hd;
    araddr <= a;
    arvalid <= 1;
    rready <= !slow;
    n = 0;
    hd = 0;
    while (!hd) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hd = rvalid && rready;
      rd = rdata;
      rs = rresp;
      n++;
      if (n > 40) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge aclk);
      if (ha) arvalid <= 0;
      if (hd) rready <= 0;
      else if (n == 3) rready <= 1;
    end
    // let an edge pass so a following call never re-drives rready in this step
    @(posedge aclk);
  endtask
  task t_drive;
    rd_reg(a2, 1);
    chk("reset value", 32'h0000_0000, rd);
    wr(a1, 32'hFFFF_FFF0, 1);
    chk("p1 enable", 32'h0000_0001, 32'(pin_oe[0]));
    chk("p1 value", 32'h0000_0001, 32'(pin_out[0]));
    repeat (10) @(posedge aclk);
    rd_reg(a1);
    chk("p1 readback", 32'h0000_0038, rd);
    wr(a1, 32'h0000_0010);
    chk("p1 low", 32'h0000_0000, 32'(pin_out[0]));
    wr(a1, 32'h0000_0000);
    chk("p1 off", 32'h0000_0000, 32'(pin_oe[0]));
    wr(a2, 32'h0000_0030);
    chk("p2 pins", 32'h0000_0003, 32'({pin_oe[1], pin_out[1]}));
    wr(a2, 32'h0000_0000);
    wr(10'h208, 32'h0000_0001);
    chk("unmapped write", 32'(pin_port_pkg::resp_slverr), 32'(rs));
    rd_reg(10'h200);
    chk("unmapped read", 32'(pin_port_pkg::resp_slverr), 32'(rs));
    $display("t_drive done");
  endtask
  task t_level;
    ext[0] <= 1;
    repeat (10) @(posedge aclk);
    rd_reg(a1);
    chk("track", 32'h0000_0008, rd);
    wr(a1, 32'h0000_0002);
    repeat (10) @(posedge aclk);
    rd_reg(a1);
    chk("inverted", 32'h0000_0002, rd);
    wr(a1, 32'h0000_0006);
    ext[0] <= 0;
    repeat (10) @(posedge aclk);
    rd_reg(a1);
    chk("held clear", 32'h0000_0006, rd);
    wr(a1, 32'h0000_0002);
    repeat (10) @(posedge aclk);
    rd_reg(a1);
    chk("resumed", 32'h0000_000A, rd);
    wr(a1, 32'h0000_0000);
    $display("t_level done");
  endtask
  task t_edge;
    logic [9:0] a;
    wr(pin_port_pkg::irq_mask_addr, 32'h0000_0001);
    for (int p = 0; p < 2; p++) begin
      a = p ? a2 : a1;
      wr(a, 32'h0000_0001);
      ext[p] <= 1;
      repeat (2) @(posedge aclk);
      ext[p] <= 0;
      repeat (10) @(posedge aclk);
      rd_reg(a);
      chk("short pulse", 32'h0000_0001, rd);
      ext[p] <= 1;
      repeat (10) @(posedge aclk);
      ext[p] <= 0;
      repeat (10) @(posedge aclk);
      rd_reg(a);
      chk("rise sticky", 32'h0000_0009, rd);
      chk("irq", 32'(p == 0), 32'(irq));
      wr(pin_port_pkg::irq_mask_addr, 32'h0000_0003);
      chk("irq unmasked", 32'h0000_0001, 32'(irq));
      rd_reg(ast);
      @(posedge aclk);
      chk("status", 32'(1 << p), rd);
      chk("irq cleared", 32'h0000_0000, 32'(irq));
      wr(a, 32'h0000_0005);
      ext[p] <= 1;
      repeat (10) @(posedge aclk);
      ext[p] <= 0;
      repeat (10) @(posedge aclk);
      wr(a, 32'h0000_0003);
      repeat (10) @(posedge aclk);
      rd_reg(a);
      chk("edge lost in clear", 32'h0000_0003, rd);
      ext[p] <= 1;
      repeat (10) @(posedge aclk);
      rd_reg(a);
      chk("rise ignored", 32'h0000_0003, rd);
      ext[p] <= 0;
      repeat (10) @(posedge aclk);
      rd_reg(a);
      chk("fall caught", 32'h0000_000B, rd);
      wr(a, 32'h0000_0004);
      wr(a, 32'h0000_0000);
      rd_reg(ast);
      wr(pin_port_pkg::irq_mask_addr, 32'h0000_0001);
    end
    $display("t_edge done");
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'h1;
    ext = 2'h0;
    aresetn = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_drive();
    t_level();
    t_edge();
    give_verdict();
  end
  // the tests need well under a thousand cycles; this is far beyond
  initial begin
    repeat (6000) @(posedge aclk);
    n_mismatch++;
    $display("[ERR] run end expected done seen timeout");
    give_verdict();
  end
endmodule
